// [sadc_pkg.sv]
// package: converter control constants
package sadc_pkg;

    // bus geometry
    localparam int ADDR_W = 18;
    localparam int DATA_W = 32;

    // register indices; byte address is four times the index
    localparam logic [15:0] IDX_RESULT = 16'hFF08;
    localparam logic [15:0] IDX_RESULT_HI = 16'hFF09;
    localparam logic [15:0] IDX_CHANNEL = 16'hFF0E;
    localparam logic [15:0] IDX_MODE = 16'hFF10;
    localparam logic [15:0] IDX_AMP_CTRL = 16'hFF11;
    localparam logic [15:0] IDX_STATUS = 16'hFF12;
    localparam logic [15:0] IDX_DIR = 16'hFF22;
    localparam logic [15:0] IDX_PORT_CFG = 16'hFF97;

    localparam logic [ADDR_W-1:0] ADDR_RESULT = {IDX_RESULT, 2'b00};
    localparam logic [ADDR_W-1:0] ADDR_RESULT_HI = {IDX_RESULT_HI, 2'b00};
    localparam logic [ADDR_W-1:0] ADDR_CHANNEL = {IDX_CHANNEL, 2'b00};
    localparam logic [ADDR_W-1:0] ADDR_MODE = {IDX_MODE, 2'b00};
    localparam logic [ADDR_W-1:0] ADDR_AMP_CTRL = {IDX_AMP_CTRL, 2'b00};
    localparam logic [ADDR_W-1:0] ADDR_STATUS = {IDX_STATUS, 2'b00};
    localparam logic [ADDR_W-1:0] ADDR_DIR = {IDX_DIR, 2'b00};
    localparam logic [ADDR_W-1:0] ADDR_PORT_CFG = {IDX_PORT_CFG, 2'b00};

    // converter mode register fields
    localparam int MODE_ENABLE_BIT = 0;
    localparam int MODE_RANGE_LSB = 1;
    localparam int MODE_TIME_LSB = 3;
    localparam int MODE_START_BIT = 7;

    // amplifier control fields and masks
    localparam int AMP0_EN_BIT = 7;
    localparam int AMP1_EN_BIT = 3;
    localparam logic [7:0] AMP_CTRL_MASK = 8'h88;
    localparam logic [7:0] CHANNEL_MASK = 8'h07;

    // pin roles
    localparam logic [7:0] AMP_IN_PINS = 8'hA5;
    localparam logic [7:0] AMP_OUT_PINS = 8'h42;
    localparam logic [7:0] AMP1_PINS = 8'hE0;

    // status register fields
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_READY_BIT = 1;
    localparam int STAT_SAMPLE_BIT = 2;
    localparam int STAT_CFG_ERR_BIT = 3;

    // reset values
    localparam logic [7:0] MODE_RESET = 8'h00;
    localparam logic [7:0] CHANNEL_RESET = 8'h00;
    localparam logic [7:0] AMP_CTRL_RESET = 8'h00;
    localparam logic [7:0] DIR_RESET = 8'hFF;
    localparam logic [7:0] PORT_CFG_RESET = 8'h00;
    localparam logic [15:0] RESULT_RESET = 16'h0000;

    // timing
    localparam int CLK_MHZ = 250;
    localparam int SETTLE_NS = 1000;
    localparam int SETTLE_CYCLES = (SETTLE_NS * CLK_MHZ + 999) / 1000;
    localparam int SAMPLE_TICKS = 4;

    // sequencer states
    typedef enum logic [1:0] {ST_IDLE, ST_SAMPLE, ST_CONVERT} sadc_state_t;

    // conversion clock divisor
    function automatic logic [3:0] conv_divisor(input logic [2:0] fr);
        logic [3:0] d;
        d = 4'hC;
        case (fr)
            3'h0: d = 4'hC;
            3'h1: d = 4'h8;
            3'h2: d = 4'h6;
            3'h3: d = 4'h4;
            3'h4: d = 4'h3;
            3'h5: d = 4'h2;
            default: d = 4'hC;
        endcase
        return d;
    endfunction

endpackage

// [sadc_sar_seq.sv]
// module: sample and binary search sequencer
`timescale 1ns/1ps
module sadc_sar_seq #(
    parameter int BITS = 10,
    parameter int SAMPLE_TICKS = sadc_pkg::SAMPLE_TICKS
) (
    // clock, reset, enable
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    // control
    input wire logic launch,
    input wire logic abort,
    input wire logic tick,
    // comparator
    input wire logic comp_greater,
    // status and data
    output logic sampling,
    output logic busy,
    output logic done,
    output logic [BITS-1:0] trial
);
    localparam int IDX_W = (BITS > 1) ? $clog2(BITS) : 1;
    localparam int CNT_W = (SAMPLE_TICKS > 1) ? $clog2(SAMPLE_TICKS) : 1;

    sadc_pkg::sadc_state_t state;
    logic [IDX_W-1:0] bit_idx;
    logic [CNT_W-1:0] samp_cnt;
    logic [BITS-1:0] sar;

    if (SAMPLE_TICKS < 1 || BITS < 2) begin : g_bad_param
        $error("sadc_sar_seq: unsupported parameters");
    end

    // status views of the state
    assign sampling = (state == sadc_pkg::ST_SAMPLE);
    assign busy = (state != sadc_pkg::ST_IDLE);
    assign trial = sar;

    // sample, then one bit per tick
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state <= sadc_pkg::ST_IDLE;
            bit_idx <= '0;
            samp_cnt <= '0;
            sar <= '0;
            done <= 1'b0;
        end
        else if (ce)
        begin
            done <= 1'b0;
            if (abort)
            begin
                state <= sadc_pkg::ST_IDLE; // RULE_10 RULE_20
            end
            else
            begin
                case (state)
                    sadc_pkg::ST_IDLE:
                    begin
                        if (launch)
                        begin
                            state <= sadc_pkg::ST_SAMPLE; // RULE_05
                            samp_cnt <= '0;
                        end
                    end
                    sadc_pkg::ST_SAMPLE:
                    begin
                        if (tick)
                        begin
                            if (samp_cnt == CNT_W'(SAMPLE_TICKS - 1))
                            begin
                                state <= sadc_pkg::ST_CONVERT; // RULE_05
                                sar <= {1'b1, {(BITS-1){1'b0}}}; // RULE_06
                                bit_idx <= IDX_W'(BITS - 1);
                            end
                            else
                            begin
                                samp_cnt <= samp_cnt + 1'b1;
                            end
                        end
                    end
                    sadc_pkg::ST_CONVERT:
                    begin
                        if (tick)
                        begin
                            sar[bit_idx] <= comp_greater; // RULE_06 RULE_07 RULE_13
                            if (bit_idx == '0)
                            begin
                                state <= sadc_pkg::ST_IDLE;
                                done <= 1'b1; // RULE_08 RULE_23
                            end
                            else
                            begin
                                sar[bit_idx - 1'b1] <= 1'b1; // RULE_07 RULE_08
                                bit_idx <= bit_idx - 1'b1; // RULE_23
                            end
                        end
                    end
                    default: state <= sadc_pkg::ST_IDLE;
                endcase
            end
        end
    end
endmodule

// [sadc_ctrl.sv]
// module: converter control top
//
// Overview of operation
// RULE_01: time and range bits set first
// RULE_02: enable bit powers the comparator
// RULE_03: wait settling time after enabling; the code does not wait, the settling count is status only
// RULE_04: start bit converts selected channel
// RULE_05: fixed sampling, then hold until end
// RULE_06: bit nine tried first at half scale
// RULE_07: bit eight tried at quarter points
// RULE_08: ten decisions, then latch and interrupt
// RULE_09: repeat while start bit stays set
// RULE_10: channel write aborts and restarts
// RULE_11: reset clears both result views
// RULE_12: restart needs only start when enabled
// RULE_13: result is rounded input ratio
// RULE_14: direction zero drives, one is input
// RULE_15: reset sets all direction bits
// RULE_16: analog pins need input direction
// RULE_17: latch ignored on analog pins
// RULE_18: amplifier input pin also converted
// RULE_19: amplifier output pin is converted
// RULE_20: clearing start halts, keeps result
// RULE_21: config write at end suppresses load
// RULE_22: result left justified, low six zero
// RULE_23: one bit per tick, one done pulse
// RULE_24: digital or driven analog pins invalid
//
// The APB interface to the registers is this design's own decision.
`timescale 1ns/1ps
module sadc_ctrl #(
    parameter int RES_BITS = 10,
    parameter int SAMPLE_TICKS = sadc_pkg::SAMPLE_TICKS
) (
    // clock, reset, enable
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [sadc_pkg::ADDR_W-1:0] paddr,
    input wire logic [sadc_pkg::DATA_W-1:0] pwdata,
    output logic [sadc_pkg::DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    // analog core
    output logic comp_enable,
    output logic sample_phase,
    output logic [RES_BITS-1:0] tap_code,
    input wire logic comp_greater,
    output logic [2:0] conv_channel,
    output logic conv_from_amp,
    output logic conv_channel_valid,
    // operational amplifiers
    output logic [1:0] amp_enable,
    output logic [7:0] amp_input_route,
    // port 2 pads
    input wire logic [7:0] port2_latch,
    input wire logic [7:0] port2_pad_in,
    output logic [7:0] port2_pad_out,
    output logic [7:0] port2_pad_oe_n,
    output logic [7:0] port2_digital_in,
    output logic [7:0] config_error,
    // conversion end event
    output logic conversion_end_irq
);
    localparam int PAD = 16 - RES_BITS;
    localparam int SETTLE_W = $clog2(sadc_pkg::SETTLE_CYCLES + 1);

    if (RES_BITS < 8 || RES_BITS > 15) begin : g_bad_res
        $error("sadc_ctrl: RES_BITS must lie in 8..15");
    end

    // software registers
    logic [7:0] converter_mode_reg;
    logic [7:0] channel_select_reg;
    logic [7:0] amplifier_control_reg;
    logic [7:0] port2_direction;
    logic [7:0] port_analog_digital_select;

    logic [15:0] result_reg_16bit;
    logic [7:0] result_reg_upper8;

    // internal state
    logic [3:0] div_cnt;
    logic [SETTLE_W-1:0] settle_cnt;

    logic [sadc_pkg::DATA_W-1:0] next_prdata;

    // bus decode
    wire setup_phase = psel & ~penable;
    wire access_phase = psel & penable;
    wire wr_fire = access_phase & pwrite & ce;

    wire hit_result = (paddr == sadc_pkg::ADDR_RESULT);
    wire hit_result_hi = (paddr == sadc_pkg::ADDR_RESULT_HI);
    wire hit_channel = (paddr == sadc_pkg::ADDR_CHANNEL);
    wire hit_mode = (paddr == sadc_pkg::ADDR_MODE);
    wire hit_amp = (paddr == sadc_pkg::ADDR_AMP_CTRL);
    wire hit_status = (paddr == sadc_pkg::ADDR_STATUS);
    wire hit_dir = (paddr == sadc_pkg::ADDR_DIR);
    wire hit_port_cfg = (paddr == sadc_pkg::ADDR_PORT_CFG);
    wire mapped = hit_result | hit_result_hi | hit_channel | hit_mode | hit_amp
                  | hit_status | hit_dir | hit_port_cfg;

    wire wr_mode = wr_fire & hit_mode;
    wire wr_channel = wr_fire & hit_channel;
    wire wr_amp = wr_fire & hit_amp;
    wire wr_dir = wr_fire & hit_dir;
    wire wr_port_cfg = wr_fire & hit_port_cfg;

    // zero-wait slave, error on unmapped
    assign pready = 1'b1;
    assign pslverr = access_phase & ~mapped;

    // mode fields
    wire conv_enable = converter_mode_reg[sadc_pkg::MODE_ENABLE_BIT];
    wire conv_start = converter_mode_reg[sadc_pkg::MODE_START_BIT];
    wire [2:0] conversion_time_field = converter_mode_reg[sadc_pkg::MODE_TIME_LSB +: 3];

    wire [3:0] divisor = sadc_pkg::conv_divisor(conversion_time_field); // RULE_01

    // amplifier enables
    assign amp_enable[0] = amplifier_control_reg[sadc_pkg::AMP0_EN_BIT];
    assign amp_enable[1] = amplifier_control_reg[sadc_pkg::AMP1_EN_BIT];

    // comparator power follows the enable bit
    assign comp_enable = conv_enable; // RULE_02
    wire comp_ready = (settle_cnt == SETTLE_W'(sadc_pkg::SETTLE_CYCLES));

    // per-pin function matrix
    wire [7:0] pin_analog = ~port_analog_digital_select;
    wire [7:0] pin_input = port2_direction;
    wire [7:0] pin_amp_en;
    wire [7:0] pin_selected;

    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++)
        begin : g_pin
            assign pin_amp_en[gi] = sadc_pkg::AMP1_PINS[gi] ? amp_enable[1] : amp_enable[0];
            assign pin_selected[gi] = (channel_select_reg[2:0] == 3'(gi));

            // pad driver: digital pins in output mode only
            assign port2_pad_oe_n[gi] = ~(~pin_analog[gi] & ~pin_input[gi]); // RULE_14
            assign port2_pad_out[gi] = ~port2_pad_oe_n[gi] & port2_latch[gi]; // RULE_17
            assign port2_digital_in[gi] = ~pin_analog[gi] & pin_input[gi] & port2_pad_in[gi];

            // amplifier input path on analog input-mode pins
            assign amp_input_route[gi] = sadc_pkg::AMP_IN_PINS[gi] & pin_analog[gi]
                                         & pin_input[gi] & pin_amp_en[gi]; // RULE_18

            // prohibited combinations
            assign config_error[gi] = (pin_analog[gi] & ~pin_input[gi]) // RULE_16 RULE_24
                | (~pin_analog[gi] & pin_selected[gi]) // RULE_24
                | (~pin_analog[gi] & sadc_pkg::AMP_OUT_PINS[gi] & pin_amp_en[gi]);
        end
    endgenerate

    // converter input routing
    assign conv_channel = channel_select_reg[2:0]; // RULE_04
    wire sel_analog_in = pin_analog[conv_channel] & pin_input[conv_channel]; // RULE_16
    assign conv_channel_valid = sel_analog_in & ~config_error[conv_channel]; // RULE_24 RULE_18
    assign conv_from_amp = conv_channel_valid & sadc_pkg::AMP_OUT_PINS[conv_channel]
                           & pin_amp_en[conv_channel]; // RULE_19

    // sequencer control
    logic seq_busy;
    logic seq_done;
    logic seq_sampling;
    logic [RES_BITS-1:0] seq_trial;

    // abort wins over launch
    wire cfg_write = wr_mode | wr_channel | wr_port_cfg;
    wire seq_abort = wr_channel | ~conv_start | ~conv_enable; // RULE_10 RULE_20
    wire seq_launch = conv_start & conv_enable & conv_channel_valid
                      & ~seq_busy; // RULE_04 RULE_09 RULE_12
    wire conv_tick = seq_busy & (div_cnt == divisor - 4'h1); // RULE_23
    wire result_load = seq_done & ~cfg_write; // RULE_21

    sadc_sar_seq #(
        .BITS(RES_BITS),
        .SAMPLE_TICKS(SAMPLE_TICKS)
    ) u_seq (
        .pclk(pclk),
        .presetn(presetn),
        .ce(ce),
        .launch(seq_launch),
        .abort(seq_abort),
        .tick(conv_tick),
        .comp_greater(comp_greater),
        .sampling(seq_sampling),
        .busy(seq_busy),
        .done(seq_done),
        .trial(seq_trial)
    );

    // analog handshake: sample switch and tap code
    assign sample_phase = seq_sampling; // RULE_05
    assign tap_code = seq_trial; // RULE_06 RULE_07

    // conversion clock divider
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            div_cnt <= 4'h0;
        end
        else if (ce)
        begin
            if (!seq_busy || conv_tick)
                div_cnt <= 4'h0;
            else
                div_cnt <= div_cnt + 4'h1;
        end
    end

    // comparator settling counter, cleared while disabled
    // status only, never blocks start
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            settle_cnt <= '0;
        end
        else if (ce)
        begin
            if (!conv_enable)
                settle_cnt <= '0;
            else if (!comp_ready)
                settle_cnt <= settle_cnt + 1'b1;
        end
    end

    // mode, channel and amplifier registers
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            converter_mode_reg <= sadc_pkg::MODE_RESET;
            channel_select_reg <= sadc_pkg::CHANNEL_RESET;
            amplifier_control_reg <= sadc_pkg::AMP_CTRL_RESET;
        end
        else
        begin
            // ce is folded into the strobes
            if (wr_mode)
                converter_mode_reg <= pwdata[7:0];
            if (wr_channel)
                channel_select_reg <= pwdata[7:0] & sadc_pkg::CHANNEL_MASK;
            if (wr_amp)
                amplifier_control_reg <= pwdata[7:0] & sadc_pkg::AMP_CTRL_MASK;
        end
    end

    // port configuration registers
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            port2_direction <= sadc_pkg::DIR_RESET; // RULE_15
            port_analog_digital_select <= sadc_pkg::PORT_CFG_RESET;
        end
        else
        begin
            if (wr_dir)
                port2_direction <= pwdata[7:0]; // RULE_14
            if (wr_port_cfg)
                port_analog_digital_select <= pwdata[7:0];
        end
    end

    // result registers
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            result_reg_16bit <= sadc_pkg::RESULT_RESET; // RULE_11
            result_reg_upper8 <= sadc_pkg::RESULT_RESET[15:8]; // RULE_11
        end
        else if (ce && result_load)
        begin
            result_reg_16bit <= {seq_trial, {PAD{1'b0}}}; // RULE_08 RULE_22
            result_reg_upper8 <= seq_trial[RES_BITS-1 -: 8];
        end
    end

    // conversion end pulse
    // one cycle, right after the load
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            conversion_end_irq <= 1'b0;
        end
        else if (ce)
        begin
            conversion_end_irq <= result_load; // RULE_08 RULE_21 RULE_23
        end
    end

    // read mux
    always_comb
    begin
        next_prdata = '0;
        if (hit_result)
            next_prdata[15:0] = result_reg_16bit;
        else if (hit_result_hi)
            next_prdata[7:0] = result_reg_upper8;
        else if (hit_channel)
            next_prdata[7:0] = channel_select_reg;
        else if (hit_mode)
            next_prdata[7:0] = converter_mode_reg;
        else if (hit_amp)
            next_prdata[7:0] = amplifier_control_reg;
        else if (hit_dir)
            next_prdata[7:0] = port2_direction;
        else if (hit_port_cfg)
            next_prdata[7:0] = port_analog_digital_select;
        else if (hit_status)
        begin
            next_prdata[sadc_pkg::STAT_BUSY_BIT] = seq_busy;
            next_prdata[sadc_pkg::STAT_READY_BIT] = comp_ready;
            next_prdata[sadc_pkg::STAT_SAMPLE_BIT] = seq_sampling;
            next_prdata[sadc_pkg::STAT_CFG_ERR_BIT] = |config_error;
        end
    end

    // read data captured in the setup cycle
    // held through the access phase
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata <= '0;
        end
        else if (ce && setup_phase)
        begin
            prdata <= next_prdata;
        end
    end
endmodule

// [sadc_analog_model.sv]
// model: analog pins and comparator
`timescale 1ns/1ps
module sadc_analog_model (
    // clock
    input wire logic pclk,
    // converter side
    input wire logic comp_enable,
    input wire logic sample_phase,
    input wire logic [9:0] tap_code,
    input wire logic [2:0] conv_channel,
    output logic comp_greater
);
    logic [9:0] vin [8];
    logic [9:0] held;
    logic flip = 1'b0;
    // track while sampling, then hold
    always @(posedge pclk)
    begin
        flip <= !flip;
        if (sample_phase)
            held <= vin[conv_channel];
    end
    // input at or above tap; unpowered comparator gives noise
    assign comp_greater = comp_enable ? (held >= tap_code) : flip;
endmodule

// [sadc_ctrl_chk.sv]
// checker: converter control assertions
`timescale 1ns/1ps
module sadc_ctrl_chk #(
    parameter int RES_BITS = 10
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [sadc_pkg::ADDR_W-1:0] paddr,
    input wire logic [sadc_pkg::DATA_W-1:0] pwdata,
    input wire logic [sadc_pkg::DATA_W-1:0] prdata,
    input wire logic pslverr,
    // converter
    input wire logic comp_enable,
    input wire logic sample_phase,
    input wire logic [RES_BITS-1:0] tap_code,
    input wire logic comp_greater,
    input wire logic [2:0] conv_channel,
    input wire logic conversion_end_irq,
    // pads
    input wire logic [7:0] port2_latch,
    input wire logic [7:0] port2_pad_out,
    input wire logic [7:0] port2_pad_oe_n
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // access decode and first trial value
    wire logic acc_wr = psel && penable && pwrite && ce;
    wire logic acc_rd = psel && penable && !pwrite;
    wire logic [RES_BITS-1:0] half = {1'b1, {(RES_BITS-1){1'b0}}};
    property p_mode_enable;
        acc_wr && paddr == sadc_pkg::ADDR_MODE |=> comp_enable == $past(pwdata[0]);
    endproperty
    a_mode_enable: assert property (p_mode_enable) else $error("enable not applied");
    property p_channel;
        acc_wr && paddr == sadc_pkg::ADDR_CHANNEL |=> conv_channel == $past(pwdata[2:0]);
    endproperty
    a_channel: assert property (p_channel) else $error("channel not applied");
    property p_sample_len;
        $rose(sample_phase) |-> sample_phase [*8];
    endproperty
    a_sample_len: assert property (p_sample_len) else $error("sampling too short");
    property p_first_trial;
        $fell(sample_phase) |-> tap_code == half;
    endproperty
    a_first_trial: assert property (p_first_trial) else $error("first trial wrong");
    property p_second_trial;
        !sample_phase && $past(tap_code) == half && tap_code != $past(tap_code)
            |-> tap_code[RES_BITS-1] == $past(comp_greater)
            && tap_code[RES_BITS-2:0] == half[RES_BITS-1:1];
    endproperty
    a_second_trial: assert property (p_second_trial) else $error("second trial wrong");
    property p_irq_pulse;
        conversion_end_irq |=> !conversion_end_irq && sample_phase == $past(sample_phase);
    endproperty
    a_irq_pulse: assert property (p_irq_pulse) else $error("end pulse too long");
    property p_result_just;
        acc_rd && paddr == sadc_pkg::ADDR_RESULT
            |-> prdata[5:0] == 6'h00 && prdata[31:16] == 16'h0000;
    endproperty
    a_result_just: assert property (p_result_just) else $error("result not left aligned");
    property p_pad_drive;
        (~port2_pad_oe_n & port2_latch) == port2_pad_out;
    endproperty
    a_pad_drive: assert property (p_pad_drive) else $error("pad drive wrong");
    property p_reset_dir;
        $rose(presetn) |-> port2_pad_oe_n == 8'hFF;
    endproperty
    a_reset_dir: assert property (p_reset_dir) else $error("pads driven after reset");
    // main scenarios
    c_irq: cover property (conversion_end_irq);
    c_hold: cover property ($fell(sample_phase));
    c_err: cover property (pslverr);
endmodule

// [test_sar_adc_sequencer_pin_config.sv]
// testbench: converter control
`timescale 1ns/1ps
module test_sar_adc_sequencer_pin_config;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [sadc_pkg::ADDR_W-1:0] paddr = '0;
    logic [31:0] pwdata = '0;
    logic [7:0] port2_latch = 8'hA5;
    logic [7:0] port2_pad_in = 8'h3C;
    logic [31:0] prdata, rd;
    logic pready, pslverr, comp_enable, sample_phase, comp_greater, conv_from_amp;
    logic conv_channel_valid, conversion_end_irq, err;
    logic [9:0] tap_code;
    logic [2:0] conv_channel;
    logic [1:0] amp_enable;
    logic [7:0] amp_input_route, port2_pad_out, port2_pad_oe_n, port2_digital_in, config_error;
    int failures = 0;
    int n_compared = 0;
    always #2 pclk = !pclk;
    sadc_ctrl #(.RES_BITS(10), .SAMPLE_TICKS(4)) dut_u (.pclk, .presetn, .ce(1'b1), .psel,
        .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .comp_enable,
        .sample_phase, .tap_code, .comp_greater, .conv_channel, .conv_from_amp,
        .conv_channel_valid, .amp_enable, .amp_input_route, .port2_latch, .port2_pad_in,
        .port2_pad_out, .port2_pad_oe_n, .port2_digital_in, .config_error,
        .conversion_end_irq);
    sadc_analog_model model_u (.pclk, .comp_enable, .sample_phase, .tap_code,
        .conv_channel, .comp_greater);
    // compare and count
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            failures++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // one apb transfer, waits for pready
    task automatic apb(input logic wr, input logic [17:0] a, input logic [31:0] d);
        int n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 50);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        check(32'(pready), 32'h1);
    endtask
    // wait for the end-of-conversion pulse
    task automatic wait_irq();
        int n = 0;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (conversion_end_irq !== 1'b1 && n < 300);
        check(32'(conversion_end_irq), 32'h1);
    endtask
    // wait into the hold phase
    task automatic mid_conv();
        do @(posedge pclk); while (sample_phase !== 1'b1);
        do @(posedge pclk); while (sample_phase !== 1'b0);
        repeat (5) @(posedge pclk);
    endtask
    // reset values and an unmapped access
    task automatic s_reset();
        check(32'(port2_pad_oe_n), 32'hFF);
        apb(1'b0, sadc_pkg::ADDR_DIR, 32'h0);
        check(rd, 32'hFF);
        apb(1'b0, sadc_pkg::ADDR_RESULT, 32'h0);
        check(rd, 32'h0);
        apb(1'b0, sadc_pkg::ADDR_RESULT_HI, 32'h0);
        check(rd, 32'h0);
        apb(1'b1, 18'h00004, 32'h0);
        check(32'(err), 32'h1);
    endtask
    // pin matrix
    task automatic s_pins();
        apb(1'b1, sadc_pkg::ADDR_PORT_CFG, 32'hFF);
        apb(1'b1, sadc_pkg::ADDR_DIR, 32'h0F);
        @(negedge pclk);
        check(32'(port2_pad_oe_n), 32'h0F);
        check(32'(port2_pad_out), 32'hA0);
        check(32'(port2_digital_in), 32'h0C);
        apb(1'b1, sadc_pkg::ADDR_PORT_CFG, 32'h00);
        @(negedge pclk);
        check(32'(port2_pad_out), 32'h00);
        check(32'(config_error), 32'hF0);
        apb(1'b1, sadc_pkg::ADDR_DIR, 32'hFF);
        apb(1'b1, sadc_pkg::ADDR_AMP_CTRL, 32'h80);
        apb(1'b1, sadc_pkg::ADDR_CHANNEL, 32'h1);
        @(negedge pclk);
        check(32'(amp_input_route), 32'h05);
        check(32'({amp_enable, conv_from_amp, conv_channel_valid}), 32'h7);
        apb(1'b1, sadc_pkg::ADDR_AMP_CTRL, 32'h0);
        apb(1'b1, sadc_pkg::ADDR_CHANNEL, 32'h0);
    endtask
    // back to back conversions
    task automatic s_convert();
        model_u.vin[0] = 10'h2B7;
        model_u.vin[2] = 10'h155;
        apb(1'b1, sadc_pkg::ADDR_MODE, 32'h29);
        repeat (250) @(posedge pclk);
        apb(1'b1, sadc_pkg::ADDR_MODE, 32'hA9);
        wait_irq();
        model_u.vin[0] = 10'h3FF;
        apb(1'b0, sadc_pkg::ADDR_RESULT, 32'h0);
        check(rd, 32'hADC0);
        apb(1'b0, sadc_pkg::ADDR_RESULT_HI, 32'h0);
        check(rd, 32'hAD);
        wait_irq();
        apb(1'b0, sadc_pkg::ADDR_RESULT, 32'h0);
        check(rd, 32'hFFC0);
    endtask
    // channel rewrite, halt and resume
    task automatic s_abort_halt();
        int k = 0;
        mid_conv();
        apb(1'b1, sadc_pkg::ADDR_CHANNEL, 32'h2);
        wait_irq();
        apb(1'b0, sadc_pkg::ADDR_RESULT, 32'h0);
        check(rd, 32'h5540);
        mid_conv();
        apb(1'b1, sadc_pkg::ADDR_MODE, 32'h29);
        repeat (60)
        begin
            @(posedge pclk);
            if (conversion_end_irq === 1'b1)
                k++;
        end
        check(32'(k), 32'h0);
        apb(1'b0, sadc_pkg::ADDR_RESULT, 32'h0);
        check(rd, 32'h5540);
        model_u.vin[2] = 10'h000;
        apb(1'b1, sadc_pkg::ADDR_MODE, 32'hA9);
        wait_irq();
        apb(1'b0, sadc_pkg::ADDR_RESULT, 32'h0);
        check(rd, 32'h0);
    endtask
    // verdict
    task automatic report_and_stop();
        $display("compared %0d, failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // main sequence
    initial
    begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        s_reset();
        s_pins();
        s_convert();
        s_abort_halt();
        report_and_stop();
    end
    // watchdog
    initial
    begin
        #100000;
        failures++;
        report_and_stop();
    end
endmodule
bind sadc_ctrl sadc_ctrl_chk #(.RES_BITS(RES_BITS)) chk_u (.pclk, .presetn, .ce, .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pslverr, .comp_enable, .sample_phase,
    .tap_code, .comp_greater, .conv_channel, .conversion_end_irq, .port2_latch,
    .port2_pad_out, .port2_pad_oe_n);
